// ===== rss_pkg.sv
// constants and types for the reset and supply supervisor
package rss_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // power-up release times, in ns
  localparam int unsigned T_START_BOR_NS = 3300000;
  localparam int unsigned T_START_NOBOR_NS = 1000000;
  localparam int unsigned START_BOR_CYC = (T_START_BOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_NOBOR_CYC = (T_START_NOBOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // wakeup latencies to run, in ns (all times round down)
  localparam int unsigned T_WAKE_SLEEP_NS = 400;
  localparam int unsigned T_WAKE_LPRUN_NS = 3000;
  localparam int unsigned T_WAKE_LPSLEEP_NS = 46000;
  localparam int unsigned T_WAKE_STOP_NS = 8000;
  localparam int unsigned T_WAKE_STANDBY_NS = 58000;
  localparam int unsigned T_WAKE_COMM_NS = 2000;
  localparam int unsigned CNT_W = 17;
  localparam logic [CNT_W-1:0] WAKE_SLEEP_CYC = CNT_W'(T_WAKE_SLEEP_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_LPRUN_CYC = CNT_W'(T_WAKE_LPRUN_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_LPSLEEP_CYC = CNT_W'(T_WAKE_LPSLEEP_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_STOP_CYC = CNT_W'(T_WAKE_STOP_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_STANDBY_CYC = CNT_W'(T_WAKE_STANDBY_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_COMM_CYC = CNT_W'(T_WAKE_COMM_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 17'h00001;
  // brownout and monitor level fields
  localparam int unsigned BOR_LVL_W = 3;
  localparam logic [BOR_LVL_W-1:0] BOR_LVL_MAX = 3'h4;
  localparam logic [BOR_LVL_W-1:0] BOR_LVL_RST = 3'h0;
  localparam int unsigned SLM_LVL_W = 3;
  localparam logic [SLM_LVL_W-1:0] SLM_LVL_MAX = 3'h6;
  localparam logic [SLM_LVL_W-1:0] SLM_LVL_RST = 3'h0;
  // regulator modes
  typedef enum logic [1:0] {REG_MAIN = 2'h0, REG_LOWPWR = 2'h1, REG_OFF = 2'h2} rss_reg_type;
  // boot sources
  typedef enum logic [1:0] {BOOT_FLASH = 2'h0, BOOT_SYSMEM = 2'h1, BOOT_SRAM = 2'h2} rss_boot_type;
  // power modes
  typedef enum logic [2:0] {
    PM_RUN = 3'h0, PM_SLEEP = 3'h1, PM_LPRUN = 3'h2,
    PM_LPSLEEP = 3'h3, PM_STOP = 3'h4, PM_STANDBY = 3'h5
  } rss_pm_type;
  // supervisor sequence
  typedef enum logic [2:0] {
    SQ_HOLD = 3'h0, SQ_START = 3'h1, SQ_OPTLOAD = 3'h2,
    SQ_BOOT = 3'h3, SQ_ACTIVE = 3'h4, SQ_WAKE = 3'h5
  } rss_seq_type;
  // output register reset image: all fields zero except the reference, so the regulator mode reads REG_MAIN
  localparam logic [23:0] OUT_RST = 24'h000100;
endpackage : rss_pkg

// ===== rss_top.sv
// reset and supply supervisor: reset hold, option load, brownout, monitor, regulator, boot, wakeup
module rss_top
  import rss_pkg::*;
#(
  parameter int unsigned START_BOR_CNT = START_BOR_CYC,
  parameter int unsigned START_NOBOR_CNT = START_NOBOR_CYC,
  parameter bit BOR_AT_POWERUP = 1'b1
)
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  // analog comparators
  input wire logic I_POR_OK,
  input wire logic I_BOR_OK,
  input wire logic I_SLM_ABOVE,
  // option bytes
  input wire logic I_OPT_VALID,
  input wire logic [BOR_LVL_W-1:0] I_OPT_BOR_LEVEL,
  input wire logic I_OPT_BOR_DIS,
  // boot pins
  input wire logic I_BOOT0,
  input wire logic I_BOOT1,
  // monitor control
  input wire logic I_SLM_EN,
  input wire logic [SLM_LVL_W-1:0] I_SLM_LEVEL,
  input wire logic I_SLM_RISE_EN,
  input wire logic I_SLM_FALL_EN,
  input wire logic I_SLM_CLR_RISE,
  input wire logic I_SLM_CLR_FALL,
  // power mode control
  input wire logic I_VREF_AUTO_OFF,
  input wire logic I_MODE_ENTER,
  input wire logic [2:0] I_MODE_REQ,
  input wire logic I_WAKE,
  input wire logic I_COMM_WAKE,
  // reset and option outputs
  output logic O_CHIP_RST_B,
  output logic O_OPT_LOAD,
  output logic O_BOR_EN,
  output logic [BOR_LVL_W-1:0] O_BOR_LEVEL,
  // monitor outputs
  output logic O_SLM_ON,
  output logic [SLM_LVL_W-1:0] O_SLM_LEVEL,
  output logic O_SLM_PEND_RISE,
  output logic O_SLM_PEND_FALL,
  output logic O_SLM_IRQ,
  // power outputs
  output logic [1:0] O_REG_MODE,
  output logic O_VREF_ON,
  output logic O_CORE_PWR,
  output logic [2:0] O_PWR_MODE,
  output logic O_RUN,
  // boot outputs
  output logic [1:0] O_BOOT_SRC,
  output logic O_LOADER_USART_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s1_d;
  logic por_ok;
  logic bor_ok;
  logic slm_above;
  logic boot0;
  logic boot1;

  always_comb
  begin
    s1_d = {I_POR_OK, I_BOR_OK, I_SLM_ABOVE, I_BOOT0, I_BOOT1};
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s1_q;
    end
  end

  assign {por_ok, bor_ok, slm_above, boot0, boot1} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // supervisor sequence
  rss_seq_type seq_q;
  rss_seq_type seq_d;
  rss_pm_type pm_q;
  rss_pm_type pm_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic bor_en_q;
  logic bor_en_d;
  logic [BOR_LVL_W-1:0] bor_lvl_q;
  logic [BOR_LVL_W-1:0] bor_lvl_d;
  rss_boot_type boot_q;
  rss_boot_type boot_d;
  logic supply_ok;
  logic [CNT_W-1:0] wake_cnt;

  always_comb
  begin
    unique case (pm_q)
      PM_SLEEP: wake_cnt = WAKE_SLEEP_CYC;
      PM_LPRUN: wake_cnt = WAKE_LPRUN_CYC;
      PM_LPSLEEP: wake_cnt = WAKE_LPSLEEP_CYC;
      PM_STOP: wake_cnt = WAKE_STOP_CYC;
      PM_STANDBY: wake_cnt = WAKE_STANDBY_CYC;
      default: wake_cnt = CNT_ZERO;
    endcase
  end

  always_comb
  begin
    supply_ok = por_ok && (!bor_en_q || bor_ok);
    seq_d = seq_q;
    pm_d = pm_q;
    cnt_d = cnt_q;
    bor_en_d = bor_en_q;
    bor_lvl_d = bor_lvl_q;
    boot_d = boot_q;
    if (!supply_ok)
    begin
      seq_d = SQ_HOLD;
      pm_d = PM_RUN;
    end
    else
    begin
      unique case (seq_q)
        SQ_HOLD:
        begin
          seq_d = SQ_START;
          cnt_d = bor_en_q ? CNT_W'(START_BOR_CNT) : CNT_W'(START_NOBOR_CNT);
        end
        SQ_START:
        begin
          if (cnt_q <= CNT_ONE)
            seq_d = SQ_OPTLOAD;
          else
            cnt_d = cnt_q - CNT_ONE;
        end
        SQ_OPTLOAD:
        begin
          if (I_OPT_VALID)
          begin
            seq_d = SQ_BOOT;
            bor_en_d = !I_OPT_BOR_DIS;
            bor_lvl_d = (I_OPT_BOR_LEVEL > BOR_LVL_MAX) ? BOR_LVL_MAX : I_OPT_BOR_LEVEL;
          end
        end
        SQ_BOOT:
        begin
          seq_d = SQ_ACTIVE;
          if (!boot0)
            boot_d = BOOT_FLASH;
          else if (!boot1)
            boot_d = BOOT_SYSMEM;
          else
            boot_d = BOOT_SRAM;
        end
        SQ_ACTIVE:
        begin
          if (pm_q == PM_RUN && I_MODE_ENTER && I_MODE_REQ <= 3'(PM_STANDBY))
            pm_d = rss_pm_type'(I_MODE_REQ);
          else if (pm_q != PM_RUN && (I_WAKE || I_COMM_WAKE))
          begin
            if (wake_cnt == CNT_ZERO && !I_COMM_WAKE)
              pm_d = PM_RUN;
            else
            begin
              seq_d = SQ_WAKE;
              cnt_d = I_COMM_WAKE ? wake_cnt + WAKE_COMM_CYC : wake_cnt;
            end
          end
        end
        SQ_WAKE:
        begin
          if (cnt_q <= CNT_ONE)
          begin
            seq_d = SQ_ACTIVE;
            pm_d = PM_RUN;
          end
          else
            cnt_d = cnt_q - CNT_ONE;
        end
        default: seq_d = SQ_HOLD;
      endcase
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      seq_q <= SQ_HOLD;
      pm_q <= PM_RUN;
      cnt_q <= CNT_ZERO;
      bor_en_q <= BOR_AT_POWERUP;
      bor_lvl_q <= BOR_LVL_RST;
      boot_q <= BOOT_FLASH;
    end
    else
    begin
      seq_q <= seq_d;
      pm_q <= pm_d;
      cnt_q <= cnt_d;
      bor_en_q <= bor_en_d;
      bor_lvl_q <= bor_lvl_d;
      boot_q <= boot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply level monitor
  logic slm_on_q;
  logic slm_on_d;
  logic prev_q;
  logic prev_d;
  logic pend_r_q;
  logic pend_r_d;
  logic pend_f_q;
  logic pend_f_d;
  logic [SLM_LVL_W-1:0] slm_lvl_q;
  logic [SLM_LVL_W-1:0] slm_lvl_d;

  always_comb
  begin
    slm_on_d = I_SLM_EN;
    slm_lvl_d = (I_SLM_LEVEL > SLM_LVL_MAX) ? SLM_LVL_MAX : I_SLM_LEVEL;
    prev_d = slm_above;
    pend_r_d = pend_r_q && !I_SLM_CLR_RISE;
    pend_f_d = pend_f_q && !I_SLM_CLR_FALL;
    if (slm_on_q && I_SLM_RISE_EN && slm_above && !prev_q)
      pend_r_d = 1'b1;
    if (slm_on_q && I_SLM_FALL_EN && !slm_above && prev_q)
      pend_f_d = 1'b1;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      slm_on_q <= 1'b0;
      slm_lvl_q <= SLM_LVL_RST;
      prev_q <= 1'b0;
      pend_r_q <= 1'b0;
      pend_f_q <= 1'b0;
    end
    else
    begin
      slm_on_q <= slm_on_d;
      slm_lvl_q <= slm_lvl_d;
      prev_q <= prev_d;
      pend_r_q <= pend_r_d;
      pend_f_q <= pend_f_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [23:0] out_d;
  logic [23:0] out_q;
  rss_reg_type reg_mode;
  logic active;

  always_comb
  begin
    active = (seq_q == SQ_ACTIVE) || (seq_q == SQ_WAKE);
    unique case (pm_q)
      PM_LPRUN, PM_LPSLEEP, PM_STOP: reg_mode = REG_LOWPWR;
      PM_STANDBY: reg_mode = REG_OFF;
      default: reg_mode = REG_MAIN;
    endcase
    out_d = {
      active,
      seq_q == SQ_OPTLOAD,
      bor_en_q,
      bor_lvl_q,
      slm_on_q,
      slm_lvl_q,
      pend_r_q,
      pend_f_q,
      pend_r_q || pend_f_q,
      2'(reg_mode),
      !(pm_q == PM_STOP && I_VREF_AUTO_OFF),
      pm_q != PM_STANDBY,
      3'(pm_q),
      active && pm_q == PM_RUN,
      2'(boot_q),
      active && boot_q == BOOT_SYSMEM
    };
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
      out_q <= OUT_RST;
    else
      out_q <= out_d;
  end

  assign {O_CHIP_RST_B, O_OPT_LOAD, O_BOR_EN, O_BOR_LEVEL, O_SLM_ON, O_SLM_LEVEL,
          O_SLM_PEND_RISE, O_SLM_PEND_FALL, O_SLM_IRQ, O_REG_MODE, O_VREF_ON,
          O_CORE_PWR, O_PWR_MODE, O_RUN, O_BOOT_SRC, O_LOADER_USART_EN} = out_q;

endmodule : rss_top

// ===== rss_top_chk.sv
// checker for the reset and supply supervisor
module rss_top_chk
  import rss_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_POR_OK,
  input wire logic I_OPT_VALID,
  input wire logic [SLM_LVL_W-1:0] I_SLM_LEVEL,
  input wire logic O_CHIP_RST_B,
  input wire logic O_OPT_LOAD,
  input wire logic O_SLM_ON,
  input wire logic [SLM_LVL_W-1:0] O_SLM_LEVEL,
  input wire logic O_SLM_PEND_RISE,
  input wire logic O_SLM_PEND_FALL,
  input wire logic O_SLM_IRQ,
  input wire logic [1:0] O_REG_MODE,
  input wire logic O_VREF_ON,
  input wire logic O_CORE_PWR,
  input wire logic [2:0] O_PWR_MODE,
  input wire logic O_RUN,
  input wire logic [1:0] O_BOOT_SRC,
  input wire logic O_LOADER_USART_EN
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);
  sequence s_lost;
    $fell(I_POR_OK);
  endsequence
  sequence s_opt;
    O_OPT_LOAD && I_OPT_VALID;
  endsequence
  property p_hold;
    s_lost |-> ##[1:4] !O_CHIP_RST_B;
  endproperty
  property p_opt;
    s_opt |-> ##[1:4] O_CHIP_RST_B;
  endproperty
  property p_lvl;
    $stable(I_SLM_LEVEL) [*3] |-> O_SLM_LEVEL == ((I_SLM_LEVEL > SLM_LVL_MAX) ? SLM_LVL_MAX : I_SLM_LEVEL);
  endproperty
  property p_pend;
    $rose(O_SLM_PEND_RISE || O_SLM_PEND_FALL) |-> O_SLM_ON;
  endproperty
  property p_irq;
    O_SLM_IRQ == (O_SLM_PEND_RISE || O_SLM_PEND_FALL);
  endproperty
  property p_main;
    O_RUN |-> O_REG_MODE == REG_MAIN && O_PWR_MODE == PM_RUN && O_VREF_ON;
  endproperty
  property p_lp;
    O_PWR_MODE inside {PM_LPRUN, PM_LPSLEEP, PM_STOP} |-> O_REG_MODE == REG_LOWPWR;
  endproperty
  property p_off;
    O_PWR_MODE == PM_STANDBY |-> O_REG_MODE == REG_OFF && !O_CORE_PWR;
  endproperty
  property p_boot;
    O_LOADER_USART_EN |-> O_BOOT_SRC == BOOT_SYSMEM && O_CHIP_RST_B;
  endproperty
  a_hold: assert property (p_hold) else $error("reset not held");
  a_opt: assert property (p_opt) else $error("no release");
  a_lvl: assert property (p_lvl) else $error("monitor level");
  a_pend: assert property (p_pend) else $error("pending while off");
  a_irq: assert property (p_irq) else $error("irq mismatch");
  a_main: assert property (p_main) else $error("run not main");
  a_lp: assert property (p_lp) else $error("not low power");
  a_off: assert property (p_off) else $error("standby power");
  a_boot: assert property (p_boot) else $error("loader enable");
endmodule : rss_top_chk
bind rss_top rss_top_chk u_chk (.*);

// ===== rss_top_tb.sv
// self-checking testbench for the reset and supply supervisor
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module rss_top_tb;
  import rss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_MCLK = 1'b0, I_RST_B = 1'b0, I_POR_OK = 1'b0, I_BOR_OK = 1'b0, I_SLM_ABOVE = 1'b0;
  logic I_OPT_VALID = 1'b0, I_OPT_BOR_DIS = 1'b0, I_BOOT0 = 1'b0, I_BOOT1 = 1'b0, I_SLM_EN = 1'b0;
  logic [2:0] I_OPT_BOR_LEVEL = 3'h0, I_SLM_LEVEL = 3'h0, I_MODE_REQ = 3'h0;
  logic I_SLM_RISE_EN = 1'b0, I_SLM_FALL_EN = 1'b0, I_SLM_CLR_RISE = 1'b0, I_SLM_CLR_FALL = 1'b0;
  logic I_VREF_AUTO_OFF = 1'b0, I_MODE_ENTER = 1'b0, I_WAKE = 1'b0, I_COMM_WAKE = 1'b0;
  logic O_CHIP_RST_B, O_OPT_LOAD, O_BOR_EN, O_SLM_ON, O_SLM_PEND_RISE, O_SLM_PEND_FALL, O_SLM_IRQ;
  logic O_VREF_ON, O_CORE_PWR, O_RUN, O_LOADER_USART_EN;
  logic [2:0] O_BOR_LEVEL, O_SLM_LEVEL, O_PWR_MODE;
  logic [1:0] O_REG_MODE, O_BOOT_SRC;
  typedef struct {int s; logic [3:0] v;} rss_note_type;
  rss_note_type q[$];
  rss_note_type e;
  logic [3:0] meas = 4'h0;
  logic [31:0] seed = 32'h9f5a;
  int n_fail = 0, check_count = 0, n;
  int lat[6] = '{10, 75, 1150, 200, 1450, 250};
  string nm[17] = '{"rst", "bor_en", "bor_lvl", "boot", "usart", "mode", "reg", "core", "vref", "slm_lvl",
    "p_rise", "p_fall", "irq", "opt_load", "timing", "run", "slm_on"};
  rss_top #(.START_BOR_CNT(20), .START_NOBOR_CNT(8)) dut (.*);
  always #20 I_MCLK = ~I_MCLK;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] act(int s);
    logic [3:0] a[17] = '{O_CHIP_RST_B, O_BOR_EN, O_BOR_LEVEL, O_BOOT_SRC, O_LOADER_USART_EN, O_PWR_MODE,
      O_REG_MODE, O_CORE_PWR, O_VREF_ON, O_SLM_LEVEL, O_SLM_PEND_RISE, O_SLM_PEND_FALL, O_SLM_IRQ, O_OPT_LOAD,
      meas, O_RUN, O_SLM_ON};
    return a[s];
  endfunction : act
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(posedge I_MCLK)
    while (q.size() > 0)
    begin
      e = q.pop_front();
      `CHK(nm[e.s], e.v, act(e.s))
    end
  task automatic note(int s, logic [3:0] v);
    q.push_back('{s, v});
  endtask : note
  task automatic cyc(int k);
    repeat (k) @(negedge I_MCLK);
  endtask : cyc
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wait_for(int s, logic [3:0] v, int lim);
    n = 0;
    while (act(s) !== v)
    begin
      cyc(1);
      n++;
      if (n > lim)
      begin
        n_fail++;
        $display("CHECK FAILED %s exp %0h got %0h", nm[s], v, act(s));
        report_and_stop();
      end
    end
  endtask : wait_for
  task automatic win(int lo, int hi);
    meas = {3'h0, n >= lo && n <= hi};
    note(14, 4'h1);
  endtask : win
  task automatic power_up(logic b0, logic b1, logic [2:0] lvl, logic dis, int t);
    {I_BOOT0, I_BOOT1, I_OPT_BOR_LEVEL, I_OPT_BOR_DIS, I_OPT_VALID} = {b0, b1, lvl, dis, 1'b0};
    I_POR_OK = 1'b1;
    I_BOR_OK = 1'b1;
    wait_for(13, 4'h1, 60);
    win(t, t + 10);
    note(0, 4'h0);
    cyc(2);
    I_OPT_VALID = 1'b1;
    wait_for(15, 4'h1, 10);
    note(3, b0 ? (b1 ? BOOT_SRAM : BOOT_SYSMEM) : BOOT_FLASH);
    note(4, b0 & ~b1);
    note(1, !dis);
    if (!dis) note(2, (lvl > BOR_LVL_MAX) ? BOR_LVL_MAX : lvl);
    cyc(1);
    I_BOR_OK = 1'b0;
    cyc(6);
    note(0, dis);
  endtask : power_up
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(8);
    I_RST_B = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0) I_POR_OK = 1'b0;
      cyc(6);
      if (i > 0) note(0, 4'h0);
      power_up(i > 0, i > 1, 3'h7 - 3'(i * 5 / 2), i[0], (i == 2) ? 8 : 20);
    end
    for (int i = 0; i < 6; i++)
    begin
      I_MODE_REQ = (i == 5) ? PM_STOP : 3'(i + 1);
      I_VREF_AUTO_OFF = (i == 3);
      I_MODE_ENTER = 1'b1;
      cyc(1);
      I_MODE_ENTER = 1'b0;
      cyc(2);
      note(5, I_MODE_REQ);
      note(6, (i == 4) ? REG_OFF : (i == 0) ? REG_MAIN : REG_LOWPWR);
      if (i == 4) note(7, 4'h0);
      if (i >= 3 && i != 4) note(8, i == 5);
      {I_WAKE, I_COMM_WAKE} = {1'b1, i == 5};
      cyc(1);
      {I_WAKE, I_COMM_WAKE} = 2'h0;
      wait_for(15, 4'h1, 1600);
      win(lat[i] - 2, lat[i] + 6);
    end
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      {I_SLM_FALL_EN, I_SLM_RISE_EN, I_SLM_LEVEL} = seed[4:0];
      I_SLM_EN = i[0];
      cyc(4);
      note(9, (I_SLM_LEVEL > SLM_LVL_MAX) ? SLM_LVL_MAX : I_SLM_LEVEL);
      note(16, I_SLM_EN);
      I_SLM_ABOVE = 1'b1;
      cyc(6);
      note(10, I_SLM_EN & I_SLM_RISE_EN);
      I_SLM_ABOVE = 1'b0;
      cyc(6);
      note(11, I_SLM_EN & I_SLM_FALL_EN);
      note(12, I_SLM_EN & (I_SLM_RISE_EN | I_SLM_FALL_EN));
      {I_SLM_CLR_RISE, I_SLM_CLR_FALL} = 2'h3;
      cyc(1);
      {I_SLM_CLR_RISE, I_SLM_CLR_FALL} = 2'h0;
      cyc(2);
      note(12, 4'h0);
    end
    cyc(2);
    report_and_stop();
  end
endmodule : rss_top_tb
